// [dv/pseq_chk_chk.sv]
// Concurrent checks on the ports of the power-state configuration block.
`timescale 1ns/1ps
module pseq_chk (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Watched ports.
	input wire pseq_pkg::apb_req_t apb_req_i,
	input wire pseq_pkg::apb_rsp_t apb_rsp_o,
	input wire logic [3:0] supply_good_i,
	input wire logic slow_clk_i,
	input wire logic wake_i,
	input wire pseq_pkg::supply_ctl_t supply_ctl_o
);
	logic rd_done;
	logic [7:0] a;
	assign rd_done = apb_rsp_o.pready && !apb_req_i.pwrite;
	assign a = apb_req_i.paddr;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_setup;
		apb_req_i.psel && !apb_req_i.penable;
	endsequence
	sequence s_access;
		apb_rsp_o.pready ##1 !apb_rsp_o.pready;
	endsequence
	a_setup_answer: assert property (s_setup |=> s_access) else $error("no answer after setup");
	a_ready_pulse: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready) else $error("ready held");
	a_ready_access: assert property (!(apb_req_i.psel && !apb_req_i.penable) |=> !apb_rsp_o.pready)
		else $error("ready outside access");
	a_rdata_idle: assert property (!apb_rsp_o.pready |-> apb_rsp_o.prdata == 32'h0)
		else $error("read data outside answer");
	a_err_unmapped: assert property (apb_rsp_o.pready && a > 8'h24 |-> apb_rsp_o.pslverr)
		else $error("unmapped not refused");
	a_err_mapped: assert property (apb_rsp_o.pready && a inside {8'h00, 8'h14, 8'h18, 8'h1C,
		8'h20, 8'h24} |-> !apb_rsp_o.pslverr) else $error("mapped refused");
	a_dwell_resv: assert property (rd_done && a inside {8'h14, 8'h1C, 8'h20}
		|-> (apb_rsp_o.prdata & 32'hFFE0_BCCE) == 32'h2) else $error("dwell reg fixed bits");
	a_awake_resv: assert property (rd_done && a == 8'h18
		|-> (apb_rsp_o.prdata & 32'hFFFF_BCCE) == 32'h2) else $error("awake reg fixed bits");
	a_ctrl_pulse: assert property (rd_done && a == 8'h00 |-> !apb_rsp_o.prdata[1])
		else $error("sleep start reads set");
	a_boot_wake1: assert property ($past(rst_i) && !rst_i |=> supply_ctl_o == 7'h08)
		else $error("wrong first wake settings");
endmodule // pseq_chk

// [dv/supply_model.sv]
// Behavioural model of the supply converters, regulators and slow oscillator.
`timescale 1ns/1ps
module supply_model (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Applied controls and settling time.
	input wire pseq_pkg::supply_ctl_t ctl_i,
	input wire logic [15:0] lag_i,
	// Good levels and free-running slow clock.
	output logic [3:0] good_o,
	output logic slow_clk_o
);
	logic [3:0] en;
	logic [3:0] en_r;
	logic [15:0] cnt_r;
	logic [7:0] div_r;
	assign en = {ctl_i.io_en, ctl_i.pll_en, ctl_i.ab_en, ctl_i.cb_en};
	// Any change of the enable set drops every good level until the lag has run out.
	assign good_o = (cnt_r >= lag_i) ? en_r : 4'h0;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			en_r <= 4'h0;
			cnt_r <= 16'h0;
			div_r <= 8'h0;
			slow_clk_o <= 1'b0;
		end else begin
			en_r <= en;
			cnt_r <= (en != en_r) ? 16'h0 : cnt_r + 16'(cnt_r != 16'hFFFF);
			div_r <= (div_r == 8'h9F) ? 8'h0 : div_r + 8'h1;
			if (div_r == 8'h9F) begin
				slow_clk_o <= ~slow_clk_o;
			end
		end
	end
endmodule // supply_model

// [dv/testbench.sv]
// Self-checking testbench of the power-state configuration block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
bind power_state_supply_config pseq_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .supply_good_i(supply_good_i),
	.slow_clk_i(slow_clk_i), .wake_i(wake_i), .supply_ctl_o(supply_ctl_o));
module testbench;
	logic mclk_i;
	logic rst_i;
	logic wake_i;
	logic slow;
	logic err;
	logic [3:0] good;
	logic [15:0] lag;
	logic [31:0] rd;
	pseq_pkg::apb_req_t req;
	pseq_pkg::apb_rsp_t rsp;
	pseq_pkg::supply_ctl_t ctl;
	int n_fail;
	int checks_done;
	int n;
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	power_state_supply_config u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .apb_req_i(req),
		.apb_rsp_o(rsp), .supply_good_i(good), .slow_clk_i(slow), .wake_i(wake_i),
		.supply_ctl_o(ctl));
	supply_model u_model (.mclk_i(mclk_i), .rst_i(rst_i), .ctl_i(ctl), .lag_i(lag),
		.good_o(good), .slow_clk_o(slow));
	task automatic close_out();
		if (n_fail == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int i;
		@(posedge mclk_i);
		req <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk_i);
			i++;
		end while (rsp.pready !== 1'b1 && i < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (i == 20) begin
			n_fail++;
			close_out();
		end
	endtask
	// Counts whole cycles during which the applied controls equal v.
	task automatic cnt_while(input logic [6:0] v, input int bound, input bit sync);
		n = 0;
		if (sync) @(negedge mclk_i);
		while (ctl === v && n < bound) begin
			n++;
			@(negedge mclk_i);
		end
		if (n >= bound) begin
			n_fail++;
			close_out();
		end
	endtask
	task automatic t_regs();
		logic [7:0] offs [4] = '{8'h14, 8'h18, 8'h1C, 8'h20};
		logic [31:0] rst_v [4] = '{32'h0010_0033, 32'h33, 32'h0010_0022, 32'h0010_0002};
		logic [31:0] one_v [4] = '{32'h001F_4333, 32'h4333, 32'h001F_4333, 32'h001F_4333};
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, offs[i], 32'h0);
			`CHK("reset value", rst_v[i], rd)
			apb(1'b1, offs[i], 32'hFFFF_FFFF);
			apb(1'b0, offs[i], 32'h0);
			`CHK("ones written", one_v[i], rd)
			apb(1'b1, offs[i], 32'h0);
			apb(1'b0, offs[i], 32'h0);
			`CHK("zeros written", 32'h2, rd)
		end
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		`CHK("unmapped error", 1'b1, err)
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		`CHK("ctrl", 32'h1, rd)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("status first wake", 32'h0002_0020, rd)
		apb(1'b1, 8'h14, 32'h0002_0033);
		apb(1'b1, 8'h18, 32'h0000_0133);
		apb(1'b1, 8'h1C, 32'h0002_0122);
		apb(1'b1, 8'h20, 32'h0003_0212);
	endtask
	task automatic t_wake();
		cnt_while(7'h08, 70000, 1'b1);
		`CHK("second wake settings", 7'h0F, ctl)
		cnt_while(7'h0F, 200, 1'b0);
		`CHK("waits for good", 1'b1, n >= 40 && n <= 50)
		repeat (2) @(negedge mclk_i);
		`CHK("awake settings", 7'h1F, ctl)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("awake code", 3'h5, rd[18:16])
		apb(1'b1, 8'h18, 32'h0000_4233);
		@(negedge mclk_i);
		`CHK("live awake write", 7'h6F, ctl)
	endtask
	task automatic t_sleep();
		lag <= 16'h3E8;
		apb(1'b1, 8'h00, 32'h3);
		cnt_while(7'h1A, 100, 1'b1);
		`CHK("first sleep stay", 32'h6, n)
		cnt_while(7'h26, 100, 1'b0);
		`CHK("second sleep stay", 32'hA, n)
		`CHK("asleep settings", 7'h00, ctl)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("sleep start cleared", 32'h1, rd)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("asleep code", 3'h1, rd[18:16])
	endtask
	initial begin
		rst_i = 1'b1;
		req = '0;
		wake_i = 1'b0;
		lag = 16'h28;
		n_fail = 0;
		checks_done = 0;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_regs();
		t_wake();
		t_sleep();
		close_out();
	end
endmodule // testbench

// [rtl/dwell_timer.sv]
// Counts two to the power of a field value in enabled ticks and holds an expiry flag.
`timescale 1ns/1ps
module dwell_timer #(
	parameter int CW = 32
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Control.
	input wire logic restart_i,
	input wire logic tick_i,
	input wire logic [4:0] log2_i,
	// Status.
	output logic expired_o
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic expired;
	} tmr_state_t;

	tmr_state_t s_r;
	tmr_state_t s_nxt;
	logic [CW-1:0] last;

	always_comb begin
		last = ~({CW{1'b1}} << log2_i);
		s_nxt = s_r;
		if (restart_i) begin
			s_nxt.cnt = '0;
			s_nxt.expired = 1'b0;
		end else if (tick_i && !s_r.expired) begin
			// The stay ends on the tick that arrives while the count holds 2**log2 - 1.
			if (s_r.cnt == last) begin
				s_nxt.expired = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expired_o = s_r.expired;
endmodule // dwell_timer

// [rtl/power_state_supply_config.sv]
// Power sequence state machine with per-state supply configuration registers on APB.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "pseq_params.svh"

// Summary of operation
// (RULE1) Second wake phase leaves only after dwell expiry and all enabled supplies good.
// (RULE2) Second wake register holds dwell plus supply and clock settings.
// (RULE3) Dwell field 20:16 gives two to that power cycles; resets to 16.
// (RULE4) Each sleep phase stays for its own dwell time before moving on.
// (RULE5) Bit 14 set stops the processor tile clock in that state.
// (RULE6) Bit 9 picks analogue buck modulation: 0 PWM, 1 PFM.
// (RULE7) Bit 8 picks core buck modulation: 0 PWM, 1 PFM.
// (RULE8) Bit 5 enables the IO supply output in that state.
// (RULE9) Bit 4 enables the PLL linear regulator in that state.
// (RULE10) Bit 1 shows analogue buck enable; read-only, reads 1 at reset.
// (RULE11) Bit 0 enables core buck; resets 1 for wake/awake, 0 sleep.
// (RULE12) Awake register has no dwell; bits 31:15 reserved and read-only.
// (RULE13) Reserved bits of dwell registers are read-only and inert.
// (RULE14) Dwell counts on the active clock, possibly the slow oscillator.
// (RULE15) Status bits 18:16 report the sequencer state as a 3-bit code.
// (RULE16) Software requests sleep with a self-clearing bit, only when awake.
// (RULE17) Wake2, awake-wait, awake; then sleep1, sleep2, asleep, applying each config.
// (RULE18) Sleep phases advance on dwell expiry without any power-good check.
module power_state_supply_config (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// APB slave.
	input wire pseq_pkg::apb_req_t apb_req_i,
	output pseq_pkg::apb_rsp_t apb_rsp_o,
	// Supply good levels: 0 core buck, 1 analogue buck, 2 PLL regulator, 3 IO output.
	input wire logic [3:0] supply_good_i,
	// Slow oscillator level and wake request level.
	input wire logic slow_clk_i,
	input wire logic wake_i,
	// Applied supply and tile clock controls.
	output pseq_pkg::supply_ctl_t supply_ctl_o
);
	typedef struct packed {
		pseq_pkg::supply_cfg_t [3:0] cfg;
		pseq_pkg::seq_state_t st;
		logic entry;
		pseq_pkg::supply_ctl_t outc;
		logic use_dflt;
		logic slow_prev;
		pseq_pkg::apb_rsp_t rsp;
	} top_state_t;

	top_state_t s_r;
	top_state_t s_nxt;
	logic [5:0] sync_q;
	logic [3:0] good_s;
	logic slow_s;
	logic wake_s;
	logic expired;
	logic tick;
	logic [4:0] dwell_sel;

	// Unpacks a register word into a configuration.
	function automatic pseq_pkg::supply_cfg_t unpack(input logic [31:0] w);
		pseq_pkg::supply_cfg_t c;
		c.dwell = w[`DWELL_MSB:`DWELL_LSB];
		c.ctl.clk_stop = w[`CLK_STOP_BIT];
		c.ctl.ab_pfm = w[`AB_PFM_BIT];
		c.ctl.cb_pfm = w[`CB_PFM_BIT];
		c.ctl.io_en = w[`IO_EN_BIT];
		c.ctl.pll_en = w[`PLL_EN_BIT];
		c.ctl.ab_en = w[`AB_EN_BIT];
		c.ctl.cb_en = w[`CB_EN_BIT];
		return c;
	endfunction

	// Packs a configuration into a read word; reserved bits read as zero.
	function automatic logic [31:0] pack(input pseq_pkg::supply_cfg_t c, input logic no_dwell);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (!no_dwell) begin
			w[`DWELL_MSB:`DWELL_LSB] = c.dwell; // [RULE2] [RULE12]
		end
		w[`CLK_STOP_BIT] = c.ctl.clk_stop;
		w[`AB_PFM_BIT] = c.ctl.ab_pfm;
		w[`CB_PFM_BIT] = c.ctl.cb_pfm;
		w[`IO_EN_BIT] = c.ctl.io_en;
		w[`PLL_EN_BIT] = c.ctl.pll_en;
		w[`AB_EN_BIT] = c.ctl.ab_en;
		w[`CB_EN_BIT] = c.ctl.cb_en;
		return w;
	endfunction

	// Maps a byte address to a configuration register index.
	function automatic logic [2:0] cfg_index(input logic [7:0] a);
		logic [2:0] i;
		case (a)
			`OFF_WAKE2: i = 3'h0;
			`OFF_AWAKE: i = 3'h1;
			`OFF_SLEEP1: i = 3'h2;
			`OFF_SLEEP2: i = 3'h3;
			default: i = 3'h4;
		endcase
		return i;
	endfunction

	// Reports the three-bit state code of a one-hot state.
	function automatic logic [2:0] state_code(input pseq_pkg::seq_state_t st);
		logic [2:0] k;
		case (st)
			pseq_pkg::ST_ASLEEP: k = `CODE_ASLEEP;
			pseq_pkg::ST_WAKE1: k = `CODE_WAKE1;
			pseq_pkg::ST_WAKE2: k = `CODE_WAKE2;
			pseq_pkg::ST_AWAKE_WAIT: k = `CODE_AWAKE_WAIT;
			pseq_pkg::ST_AWAKE: k = `CODE_AWAKE;
			pseq_pkg::ST_SLEEP1: k = `CODE_SLEEP1;
			pseq_pkg::ST_SLEEP2: k = `CODE_SLEEP2;
			default: k = `CODE_RESET;
		endcase
		return k;
	endfunction

	// Selects the configuration that a state applies.
	function automatic pseq_pkg::supply_cfg_t state_cfg(input pseq_pkg::seq_state_t st,
			input pseq_pkg::supply_cfg_t [3:0] cfg);
		pseq_pkg::supply_cfg_t c;
		case (st)
			pseq_pkg::ST_ASLEEP: c = unpack(`CFG_ASLEEP);
			pseq_pkg::ST_WAKE1: c = unpack(`CFG_WAKE1);
			pseq_pkg::ST_WAKE2: c = cfg[0];
			pseq_pkg::ST_AWAKE_WAIT: c = cfg[1];
			pseq_pkg::ST_AWAKE: c = cfg[1];
			pseq_pkg::ST_SLEEP1: c = cfg[2];
			pseq_pkg::ST_SLEEP2: c = cfg[3];
			default: c = unpack(`CFG_RESET);
		endcase
		return c;
	endfunction

	// True when every supply that the configuration enables reports good.
	function automatic logic all_good(input pseq_pkg::supply_ctl_t c, input logic [3:0] g);
		logic [3:0] en;
		en = {c.io_en, c.pll_en, c.ab_en, c.cb_en};
		return &(g | ~en);
	endfunction

	// Reset images, folded at elaboration so that the reset branch loads plain constants.
	localparam pseq_pkg::supply_cfg_t RST_CFG_WAKE2 = unpack(`RST_WAKE2);
	localparam pseq_pkg::supply_cfg_t RST_CFG_AWAKE = unpack(`RST_AWAKE);
	localparam pseq_pkg::supply_cfg_t RST_CFG_SLEEP1 = unpack(`RST_SLEEP1);
	localparam pseq_pkg::supply_cfg_t RST_CFG_SLEEP2 = unpack(`RST_SLEEP2);
	localparam pseq_pkg::supply_cfg_t RST_CFG_OFF = unpack(`CFG_RESET);

	sync2 #(
		.W(6)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({wake_i, slow_clk_i, supply_good_i}),
		.sync_o(sync_q)
	);

	assign good_s = sync_q[3:0];
	assign slow_s = sync_q[4];
	assign wake_s = sync_q[5];

	always_comb begin
		pseq_pkg::supply_cfg_t cur;
		cur = state_cfg(s_r.st, s_r.cfg);
		dwell_sel = cur.dwell;
		// Sleep phases run from the slow oscillator unless software picks the default clock.
		if ((s_r.st == pseq_pkg::ST_SLEEP1 || s_r.st == pseq_pkg::ST_SLEEP2 ||
				s_r.st == pseq_pkg::ST_ASLEEP) && !s_r.use_dflt) begin
			tick = slow_s & ~s_r.slow_prev; // [RULE14]
		end else begin
			tick = 1'b1; // [RULE14]
		end
	end

	dwell_timer #(
		.CW(32)
	) u_dwell (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.restart_i(s_r.entry),
		.tick_i(tick),
		.log2_i(dwell_sel), // [RULE3]
		.expired_o(expired)
	);

	always_comb begin
		logic [2:0] idx;
		logic setup;
		logic wr;
		logic sleep_go;
		pseq_pkg::supply_cfg_t wc;
		logic [31:0] st_word;
		pseq_pkg::supply_cfg_t ent;
		ent = '0;
		idx = cfg_index(apb_req_i.paddr);
		setup = apb_req_i.psel & ~apb_req_i.penable;
		wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & s_r.rsp.pready;
		sleep_go = 1'b0;
		wc = unpack(apb_req_i.pwdata);
		st_word = pack({5'h00, s_r.outc}, 1'b1);
		st_word[`STATE_MSB:`STATE_LSB] = state_code(s_r.st); // [RULE15]
		s_nxt = s_r;
		s_nxt.entry = 1'b0;
		s_nxt.slow_prev = slow_s;

		// Answer in the access phase that follows every setup cycle.
		s_nxt.rsp.pready = setup;
		s_nxt.rsp.pslverr = 1'b0;
		s_nxt.rsp.prdata = 32'h0000_0000;
		if (setup) begin
			if (idx[2] == 1'b0) begin
				s_nxt.rsp.prdata = pack(s_r.cfg[idx[1:0]], idx == 3'h1);
			end else if (apb_req_i.paddr == `OFF_CTRL) begin
				s_nxt.rsp.prdata[`CTRL_DFLT_CLK_BIT] = s_r.use_dflt;
			end else if (apb_req_i.paddr == `OFF_STATUS) begin
				s_nxt.rsp.prdata = st_word;
			end else begin
				s_nxt.rsp.pslverr = 1'b1;
			end
		end

		if (wr) begin
			if (idx[2] == 1'b0) begin
				// The analogue buck enable is read-only and keeps its value.
				wc.ctl.ab_en = s_r.cfg[idx[1:0]].ctl.ab_en; // [RULE10]
				if (idx == 3'h1) begin
					wc.dwell = 5'h00; // [RULE12]
				end
				s_nxt.cfg[idx[1:0]] = wc; // [RULE13]
			end else if (apb_req_i.paddr == `OFF_CTRL) begin
				s_nxt.use_dflt = apb_req_i.pwdata[`CTRL_DFLT_CLK_BIT];
				sleep_go = apb_req_i.pwdata[`CTRL_SLEEP_GO_BIT]; // [RULE16]
			end
		end

		case (s_r.st)
			pseq_pkg::ST_RESET: begin
				s_nxt.st = pseq_pkg::ST_WAKE1;
			end
			pseq_pkg::ST_ASLEEP: begin
				if (!s_r.entry && expired && wake_s) begin
					s_nxt.st = pseq_pkg::ST_WAKE1;
				end
			end
			pseq_pkg::ST_WAKE1: begin
				if (!s_r.entry && expired && all_good(s_r.outc, good_s)) begin
					s_nxt.st = pseq_pkg::ST_WAKE2;
				end
			end
			pseq_pkg::ST_WAKE2: begin
				if (!s_r.entry && expired && all_good(s_r.outc, good_s)) begin
					s_nxt.st = pseq_pkg::ST_AWAKE_WAIT; // [RULE1] [RULE17]
				end
			end
			pseq_pkg::ST_AWAKE_WAIT: begin
				s_nxt.st = pseq_pkg::ST_AWAKE; // [RULE17]
			end
			pseq_pkg::ST_AWAKE: begin
				// A sleep request outside the awake state is ignored.
				if (sleep_go) begin
					s_nxt.st = pseq_pkg::ST_SLEEP1; // [RULE16] [RULE17]
				end
			end
			pseq_pkg::ST_SLEEP1: begin
				if (!s_r.entry && expired) begin
					s_nxt.st = pseq_pkg::ST_SLEEP2; // [RULE4] [RULE18]
				end
			end
			pseq_pkg::ST_SLEEP2: begin
				if (!s_r.entry && expired) begin
					s_nxt.st = pseq_pkg::ST_ASLEEP; // [RULE4] [RULE18]
				end
			end
			default: begin
				s_nxt.st = pseq_pkg::ST_RESET;
			end
		endcase

		if (s_nxt.st != s_r.st) begin
			s_nxt.entry = 1'b1;
		end
		// Settings track the state's register, written or entered.
		ent = state_cfg(s_nxt.st, s_nxt.cfg);
		s_nxt.outc = ent.ctl; // [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE11]
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r.cfg[0] <= RST_CFG_WAKE2; // [RULE3] [RULE11]
			s_r.cfg[1] <= RST_CFG_AWAKE;
			s_r.cfg[2] <= RST_CFG_SLEEP1;
			s_r.cfg[3] <= RST_CFG_SLEEP2;
			s_r.st <= pseq_pkg::ST_RESET;
			s_r.entry <= 1'b1;
			s_r.outc <= RST_CFG_OFF.ctl;
			s_r.use_dflt <= `RST_DFLT_CLK;
			s_r.slow_prev <= 1'b0;
			s_r.rsp <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp_o = s_r.rsp;
	assign supply_ctl_o = s_r.outc;
endmodule // power_state_supply_config

// [rtl/pseq_params.svh]
// Register offsets, field positions and reset values of the power-state configuration block.
`ifndef PSEQ_PARAMS_SVH
`define PSEQ_PARAMS_SVH

`define OFF_CTRL 8'h00
`define OFF_WAKE2 8'h14
`define OFF_AWAKE 8'h18
`define OFF_SLEEP1 8'h1C
`define OFF_SLEEP2 8'h20
`define OFF_STATUS 8'h24

`define CTRL_DFLT_CLK_BIT 0
`define CTRL_SLEEP_GO_BIT 1

`define DWELL_MSB 20
`define DWELL_LSB 16
`define STATE_MSB 18
`define STATE_LSB 16
`define CLK_STOP_BIT 14
`define AB_PFM_BIT 9
`define CB_PFM_BIT 8
`define IO_EN_BIT 5
`define PLL_EN_BIT 4
`define AB_EN_BIT 1
`define CB_EN_BIT 0

`define RST_WAKE2 32'h0010_0033
`define RST_AWAKE 32'h0000_0033
`define RST_SLEEP1 32'h0010_0022
`define RST_SLEEP2 32'h0010_0002
`define CFG_WAKE1 32'h0010_0020
`define CFG_ASLEEP 32'h0010_0000
`define CFG_RESET 32'h0000_0000
`define RST_DFLT_CLK 1'b0

`define CODE_RESET 3'h0
`define CODE_ASLEEP 3'h1
`define CODE_WAKE1 3'h2
`define CODE_WAKE2 3'h3
`define CODE_AWAKE_WAIT 3'h4
`define CODE_AWAKE 3'h5
`define CODE_SLEEP1 3'h6
`define CODE_SLEEP2 3'h7

`endif

// [rtl/pseq_pkg.sv]
// Types shared by the power-state configuration block.
package pseq_pkg;

	typedef enum logic [7:0] {
		ST_RESET = 8'h01,
		ST_ASLEEP = 8'h02,
		ST_WAKE1 = 8'h04,
		ST_WAKE2 = 8'h08,
		ST_AWAKE_WAIT = 8'h10,
		ST_AWAKE = 8'h20,
		ST_SLEEP1 = 8'h40,
		ST_SLEEP2 = 8'h80
	} seq_state_t;

	typedef struct packed {
		logic clk_stop;
		logic ab_pfm;
		logic cb_pfm;
		logic io_en;
		logic pll_en;
		logic ab_en;
		logic cb_en;
	} supply_ctl_t;

	typedef struct packed {
		logic [4:0] dwell;
		supply_ctl_t ctl;
	} supply_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage

// [rtl/sync2.sv]
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Levels.
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt.meta = async_i;
		s_nxt.stab = s_r.meta;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_o = s_r.stab;
endmodule // sync2
